// file: hdl/gpt_pkg.sv
// Purpose: Constants and carrier types for the general timer unit.
// Assumes: AHB-Lite word access, 40 MHz hclk, 32.768 kHz capture pin clock.
// Notes: Offsets are byte addresses within the unit.
package gpt_pkg;

	localparam logic [7:0] OFS_CFG  = 8'h00;
	localparam logic [7:0] OFS_AMR  = 8'h04;
	localparam logic [7:0] OFS_BMR  = 8'h08;
	localparam logic [7:0] OFS_CTL  = 8'h0C;
	localparam logic [7:0] OFS_IMR  = 8'h18;
	localparam logic [7:0] OFS_RIS  = 8'h1C;
	localparam logic [7:0] OFS_MIS  = 8'h20;
	localparam logic [7:0] OFS_ICR  = 8'h24;
	localparam logic [7:0] OFS_AILR = 8'h28;
	localparam logic [7:0] OFS_BILR = 8'h2C;
	localparam logic [7:0] OFS_AMAT = 8'h30;
	localparam logic [7:0] OFS_BMAT = 8'h34;
	localparam logic [7:0] OFS_APR  = 8'h38;
	localparam logic [7:0] OFS_BPR  = 8'h3C;
	localparam logic [7:0] OFS_ACNT = 8'h48;
	localparam logic [7:0] OFS_BCNT = 8'h4C;

	localparam int CTL_EN     = 0;
	localparam int CTL_STALL  = 1;
	localparam int CTL_CLOCK_STALL_EXEMPT_ENABLE  = 4;
	localparam int CTL_OTE    = 5;
	localparam int HALF_SHIFT = 8;
	localparam int RIS_TO     = 0;
	localparam int RIS_RTC    = 3;
	localparam logic [15:0] RIS_MASK = 16'h0109;

	localparam logic [2:0] CFG_32  = 3'h0;
	localparam logic [2:0] CFG_RTC = 3'h1;
	localparam logic [2:0] CFG_16  = 3'h4;
	localparam logic [1:0] MODE_ONE = 2'h1;
	localparam logic [1:0] MODE_PER = 2'h2;

	localparam logic [15:0] CNT_RST   = 16'hFFFF;
	localparam logic [7:0]  PR_RST    = 8'h00;
	localparam logic [31:0] RTC_START = 32'h00000001;

	localparam int RTC_PIN_HZ = 32768;
	localparam int TICK_HZ    = 1;
	localparam int RTC_DIV    = RTC_PIN_HZ / TICK_HZ;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
	} gpt_req_t;

	typedef struct packed {
		logic [2:0]       cfg;
		logic [1:0][1:0]  mr;
		logic [1:0]       en;
		logic [1:0]       stall;
		logic [1:0]       ote;
		logic             clock_stall_exempt_enable;
		logic [15:0]      imr;
		logic [15:0]      ris;
		logic [1:0][15:0] cnt;
		logic [1:0][15:0] ilr;
		logic [1:0][15:0] mat;
		logic [1:0][7:0]  pr;
		logic [1:0][7:0]  ps;
		logic [31:0]      rdata;
		logic             trig;
	} gpt_core_t;

	localparam gpt_core_t CORE_RST = '{
		cnt: {CNT_RST, CNT_RST},
		ilr: {CNT_RST, CNT_RST},
		pr: {PR_RST, PR_RST},
		ps: {PR_RST, PR_RST},
		default: '0
	};

endpackage

// file: hdl/gpt_ahb_port.sv
// Purpose: AHB-Lite slave front end for the general timer unit.
// Assumes: One slave; writes take no wait state, reads take one.
// Notes: Unmapped addresses are decoded by the core.
`timescale 1ns/1ps
module gpt_ahb_port (
	// Clock and reset.
	input  wire logic              hclk,
	input  wire logic              hresetn,
	// Bus side.
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic              hready,
	output logic                   hreadyout,
	// Core side.
	output gpt_pkg::gpt_req_t      req
);

	typedef struct packed {
		logic       act;
		logic       wr;
		logic       rdy;
		logic [7:0] addr;
	} gpt_port_t;

	gpt_port_t q;
	gpt_port_t d;

	always_comb begin
		d = q;
		if (hready) begin
			d.act  = hsel && htrans[1];
			d.wr   = hwrite;
			d.rdy  = hwrite;
			d.addr = haddr[7:0];
		end else if (q.act) begin
			d.rdy = 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign hreadyout = !(q.act && !q.rdy);
	assign req.wr    = q.act && q.wr;
	assign req.rd    = q.act && !q.wr && !q.rdy;
	assign req.addr  = q.addr;

	property p_read_wait;
		@(posedge hclk) disable iff (!hresetn)
		(hsel && htrans[1] && hready && !hwrite) |=> !hreadyout ##1 hreadyout;
	endproperty
	a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");

endmodule

// file: hdl/gpt_rtc_tick.sv
// Purpose: Turns the slow capture pin clock into a one-second tick.
// Assumes: Pin clock far slower than hclk.
// Notes: DIV may be shortened for simulation.
`timescale 1ns/1ps
module gpt_rtc_tick #(
	parameter int unsigned DIV = gpt_pkg::RTC_DIV
) (
	// Clock and reset.
	input  wire logic hclk,
	input  wire logic hresetn,
	// Pin and control.
	input  wire logic pin_clk,
	input  wire logic run,
	// Tick out.
	output logic      tick
);

	typedef struct packed {
		logic        s1;
		logic        s2;
		logic        s3;
		logic [15:0] cnt;
	} gpt_tick_t;

	gpt_tick_t q;
	gpt_tick_t d;
	logic      rise;

	assign rise = q.s2 && !q.s3;
	assign tick = run && rise && (q.cnt == 16'(DIV - 1));

	always_comb begin
		d    = q;
		d.s1 = pin_clk;
		d.s2 = q.s1;
		d.s3 = q.s2;
		if (!run) begin
			d.cnt = '0;
		end else if (rise) begin
			d.cnt = tick ? 16'h0000 : q.cnt + 16'h0001;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

endmodule

// file: hdl/gpt_timer_top.sv
// Purpose: General timer unit with two halves, 32-bit and clock modes.
// Assumes: Debug halt and capture pin are synchronous inputs except the pin.
// Notes: Registers are reached over AHB-Lite.
//
// The implementer's own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module gpt_timer_top #(
	parameter int unsigned RTC_DIV_P = gpt_pkg::RTC_DIV
) (
	// Clock and reset.
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave.
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Timer pins.
	input  wire logic        debug_halt,
	input  wire logic        capture_pin_zero,
	output logic             adc_trig,
	output logic             irq
);

	gpt_pkg::gpt_req_t  req;
	gpt_pkg::gpt_core_t q;
	gpt_pkg::gpt_core_t d;
	logic               rtc_tick;
	logic               is32;
	logic               isrtc;
	logic               wide;
	logic               halt32;
	logic               rtc_halt;
	logic [15:0]        set;
	logic [15:0]        clr;
	logic [31:0]        ctlv;

	////////////////////////////////////////////////////////////////////////////
	// Bus front end and slow clock divider.

	gpt_ahb_port u_port (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hready    (hready),
		.hreadyout (hreadyout),
		.req       (req)
	);

	gpt_rtc_tick #(
		.DIV (RTC_DIV_P)
	) u_tick (
		.hclk    (hclk),
		.hresetn (hresetn),
		.pin_clk (capture_pin_zero),
		.run     (isrtc && q.en[0]),
		.tick    (rtc_tick)
	);

	////////////////////////////////////////////////////////////////////////////
	// Mode decode.

	assign is32     = (q.cfg == gpt_pkg::CFG_32);
	assign isrtc    = (q.cfg == gpt_pkg::CFG_RTC);
	assign wide     = is32 || isrtc;
	assign halt32   = debug_halt && (|q.stall);
	assign rtc_halt = halt32 && !q.clock_stall_exempt_enable;

	always_comb begin
		ctlv = '0;
		for (int i = 0; i < 2; i++) begin
			ctlv[gpt_pkg::CTL_EN + gpt_pkg::HALF_SHIFT * i]    = q.en[i];
			ctlv[gpt_pkg::CTL_STALL + gpt_pkg::HALF_SHIFT * i] = q.stall[i];
			ctlv[gpt_pkg::CTL_OTE + gpt_pkg::HALF_SHIFT * i]   = q.ote[i];
		end
		ctlv[gpt_pkg::CTL_CLOCK_STALL_EXEMPT_ENABLE] = q.clock_stall_exempt_enable;
	end

	////////////////////////////////////////////////////////////////////////////
	// Next state.

	always_comb begin
		d      = q;
		d.trig = 1'b0;
		set    = '0;
		clr    = '0;

		if (is32) begin
			// Only the first half mode field matters here.
			if (q.en[0] && !halt32) begin
				if (q.cnt == '0) begin
					d.cnt                 = q.ilr;
					set[gpt_pkg::RIS_TO]  = 1'b1;
					d.trig                = q.ote[0];
					if (q.mr[0] == gpt_pkg::MODE_ONE) begin
						d.en[0] = 1'b0;
					end
				end else begin
					d.cnt = q.cnt - 32'h00000001;
				end
			end
		end else if (isrtc) begin
			if (q.en[0] && rtc_tick && !rtc_halt) begin
				if (q.cnt == q.mat) begin
					d.cnt                 = '0;
					set[gpt_pkg::RIS_RTC] = 1'b1;
				end else begin
					d.cnt = q.cnt + 32'h00000001;
				end
			end
		end else begin
			// Any other width value runs the halves apart.
			for (int i = 0; i < 2; i++) begin
				if (q.en[i] && !(debug_halt && q.stall[i])) begin
					if (q.ps[i] != '0) begin
						d.ps[i] = q.ps[i] - 8'h01;
					end else if (q.cnt[i] == '0) begin
						d.cnt[i] = q.ilr[i];
						d.ps[i]  = q.pr[i];
						set[gpt_pkg::RIS_TO + gpt_pkg::HALF_SHIFT * i] = 1'b1;
						if (q.ote[i]) begin
							d.trig = 1'b1;
						end
						if (q.mr[i] == gpt_pkg::MODE_ONE) begin
							d.en[i] = 1'b0;
						end
					end else begin
						d.cnt[i] = q.cnt[i] - 16'h0001;
						d.ps[i]  = q.pr[i];
					end
				end
			end
		end

		if (req.wr) begin
			case (req.addr)
				gpt_pkg::OFS_CFG: begin
					d.cfg = hwdata[2:0];
					if (hwdata[2:0] == gpt_pkg::CFG_RTC && !isrtc) begin
						d.cnt = gpt_pkg::RTC_START;
					end
				end
				gpt_pkg::OFS_AMR: begin
					d.mr[0] = hwdata[1:0];
				end
				gpt_pkg::OFS_BMR: begin
					d.mr[1] = hwdata[1:0];
				end
				gpt_pkg::OFS_CTL: begin
					for (int i = 0; i < 2; i++) begin
						d.en[i]    = hwdata[gpt_pkg::CTL_EN + gpt_pkg::HALF_SHIFT * i];
						d.stall[i] = hwdata[gpt_pkg::CTL_STALL + gpt_pkg::HALF_SHIFT * i];
						d.ote[i]   = hwdata[gpt_pkg::CTL_OTE + gpt_pkg::HALF_SHIFT * i];
						if (!wide && !q.en[i]
							&& hwdata[gpt_pkg::CTL_EN + gpt_pkg::HALF_SHIFT * i]) begin
							d.cnt[i] = q.ilr[i];
							d.ps[i]  = q.pr[i];
						end
					end
					if (is32 && !q.en[0] && hwdata[gpt_pkg::CTL_EN]) begin
						d.cnt = q.ilr;
					end
					d.clock_stall_exempt_enable = hwdata[gpt_pkg::CTL_CLOCK_STALL_EXEMPT_ENABLE];
				end
				gpt_pkg::OFS_IMR: begin
					d.imr = hwdata[15:0] & gpt_pkg::RIS_MASK;
				end
				gpt_pkg::OFS_ICR: begin
					clr = hwdata[15:0];
				end
				gpt_pkg::OFS_AILR: begin
					d.ilr[0] = hwdata[15:0];
					if (wide) begin
						d.ilr[1] = hwdata[31:16];
					end
					if (is32 && q.en[0]) begin
						d.cnt = hwdata;
					end else if (!wide && q.en[0]) begin
						d.cnt[0] = hwdata[15:0];
					end
				end
				gpt_pkg::OFS_BILR: begin
					d.ilr[1] = hwdata[15:0];
					if (!wide && q.en[1]) begin
						d.cnt[1] = hwdata[15:0];
					end
				end
				gpt_pkg::OFS_AMAT: begin
					d.mat[0] = hwdata[15:0];
					if (wide) begin
						d.mat[1] = hwdata[31:16];
					end
				end
				gpt_pkg::OFS_BMAT: begin
					d.mat[1] = hwdata[15:0];
				end
				gpt_pkg::OFS_APR: begin
					d.pr[0] = hwdata[7:0];
				end
				gpt_pkg::OFS_BPR: begin
					d.pr[1] = hwdata[7:0];
				end
				default: begin
				end
			endcase
		end

		// A new event wins over a clear in the same cycle.
		d.ris = (q.ris & ~clr) | set;

		if (req.rd) begin
			case (req.addr)
				gpt_pkg::OFS_CFG:  d.rdata = {29'h0, q.cfg};
				gpt_pkg::OFS_AMR:  d.rdata = {30'h0, q.mr[0]};
				gpt_pkg::OFS_BMR:  d.rdata = {30'h0, q.mr[1]};
				gpt_pkg::OFS_CTL:  d.rdata = ctlv;
				gpt_pkg::OFS_IMR:  d.rdata = {16'h0, q.imr};
				gpt_pkg::OFS_RIS:  d.rdata = {16'h0, q.ris};
				gpt_pkg::OFS_MIS:  d.rdata = {16'h0, q.ris & q.imr};
				gpt_pkg::OFS_AILR: d.rdata = wide ? q.ilr : {16'h0, q.ilr[0]};
				gpt_pkg::OFS_BILR: d.rdata = {16'h0, q.ilr[1]};
				gpt_pkg::OFS_AMAT: d.rdata = wide ? q.mat : {16'h0, q.mat[0]};
				gpt_pkg::OFS_BMAT: d.rdata = {16'h0, q.mat[1]};
				gpt_pkg::OFS_APR:  d.rdata = {24'h0, q.pr[0]};
				gpt_pkg::OFS_BPR:  d.rdata = {24'h0, q.pr[1]};
				gpt_pkg::OFS_ACNT: d.rdata = wide ? q.cnt : {16'h0, q.cnt[0]};
				gpt_pkg::OFS_BCNT: d.rdata = {16'h0, q.cnt[1]};
				default:           d.rdata = '0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register.

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= gpt_pkg::CORE_RST;
		end else begin
			q <= d;
		end
	end

	assign hrdata   = q.rdata;
	assign hresp    = 1'b0;
	assign adc_trig = q.trig;
	assign irq      = |(q.ris & q.imr);

	////////////////////////////////////////////////////////////////////////////
	// Checks.

	sequence s_hit32;
		is32 && q.en[0] && !halt32 && (q.cnt == '0) && !req.wr;
	endsequence

	sequence s_zero32;
		is32 && q.en[0] && !halt32 && (q.cnt == '0);
	endsequence

	property p_reset_vals;
		@(posedge hclk) disable iff (!hresetn)
		$rose(hresetn) |-> (q.cnt == 32'hFFFFFFFF) && (q.ilr == 32'hFFFFFFFF)
			&& (q.ps == '0) && (q.pr == '0) && (q.en == '0);
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

	property p_oneshot_stop;
		@(posedge hclk) disable iff (!hresetn)
		s_hit32 ##0 (q.mr[0] == gpt_pkg::MODE_ONE) |=> !q.en[0];
	endproperty
	a_oneshot_stop: assert property (p_oneshot_stop) else $error("one-shot kept running");

	property p_reload;
		@(posedge hclk) disable iff (!hresetn)
		s_hit32 |=> (q.cnt == $past(q.ilr)) && q.ris[gpt_pkg::RIS_TO];
	endproperty
	a_reload: assert property (p_reload) else $error("no reload or time-out flag");

	property p_trig_cause;
		@(posedge hclk) disable iff (!hresetn)
		adc_trig |-> $past(|q.ote) && $past(|set);
	endproperty
	a_trig_cause: assert property (p_trig_cause) else $error("trigger without cause");

	property p_irq_on_hit;
		@(posedge hclk) disable iff (!hresetn)
		s_hit32 ##0 q.imr[gpt_pkg::RIS_TO] |=> irq;
	endproperty
	a_irq_on_hit: assert property (p_irq_on_hit) else $error("unmasked time-out no irq");

	property p_load_write;
		@(posedge hclk) disable iff (!hresetn)
		req.wr && (req.addr == gpt_pkg::OFS_AILR) && is32 && q.en[0]
			|=> q.cnt == $past(hwdata);
	endproperty
	a_load_write: assert property (p_load_write) else $error("load write not taken");

	property p_stall;
		@(posedge hclk) disable iff (!hresetn)
		is32 && q.en[0] && halt32 && !req.wr |=> $stable(q.cnt);
	endproperty
	a_stall: assert property (p_stall) else $error("counter moved while stalled");

	property p_rtc_start;
		@(posedge hclk) disable iff (!hresetn)
		req.wr && (req.addr == gpt_pkg::OFS_CFG) && (hwdata[2:0] == gpt_pkg::CFG_RTC)
			&& !isrtc |=> isrtc && (q.cnt == 32'h00000001);
	endproperty
	a_rtc_start: assert property (p_rtc_start) else $error("clock mode start not one");

	property p_rtc_roll;
		@(posedge hclk) disable iff (!hresetn)
		isrtc && q.en[0] && rtc_tick && !rtc_halt && (q.cnt == q.mat) && !req.wr
			|=> (q.cnt == '0) && q.ris[gpt_pkg::RIS_RTC];
	endproperty
	a_rtc_roll: assert property (p_rtc_roll) else $error("clock match no roll");

	property p_set_wins;
		@(posedge hclk) disable iff (!hresetn)
		s_zero32 ##0 (req.wr && req.addr == gpt_pkg::OFS_ICR) |=> q.ris[gpt_pkg::RIS_TO];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("event lost to clear");

endmodule

// file: dv/gpt_pin_clk_src.sv
// Purpose: Slow capture pin clock source for clock mode.
// Assumes: The pin rests low whenever no run is requested.
// Notes: The default half period gives a 32.768 kHz pin clock.
`timescale 1ns/1ps
module gpt_pin_clk_src #(
	parameter real HALF_NS = 15258.789
) (
	// Control.
	input  wire logic run,
	// Pin.
	output logic      pin
);
	initial begin
		pin = 1'b0;
		forever begin
			wait (run === 1'b1);
			#(HALF_NS) pin = 1'b1;
			#(HALF_NS) pin = 1'b0;
		end
	end
endmodule

// file: dv/gpt_timer_top_tb.sv
// Purpose: Self-checking bench for the general timer unit.
// Assumes: One AHB-Lite master, hready tied to hreadyout.
// Notes: The clock divider is shortened to 4 rising pin edges per tick.
`timescale 1ns/1ps
module gpt_timer_top_tb;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        debug_halt;
	logic        pin_clk;
	logic        pin_run;
	logic        adc_trig;
	logic        irq;
	logic [31:0] q;
	logic [31:0] q2;
	int          n_fail = 0;
	int          tests_run = 0;
	int          cyc = 0;
	int          n_trig = 0;
	int          n0 = 0;
	int          last_trig = 0;
	int          trig_gap = 0;

	gpt_timer_top #(.RTC_DIV_P(4)) u_gpt_timer_top (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .debug_halt(debug_halt),
		.capture_pin_zero(pin_clk), .adc_trig(adc_trig), .irq(irq)
	);

	gpt_pin_clk_src u_gpt_pin_clk_src (.run(pin_run), .pin(pin_clk));

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end

	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (adc_trig === 1'b1) begin
			n_trig <= n_trig + 1;
			trig_gap <= cyc - last_trig;
			last_trig <= cyc;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		haddr <= {24'h000000, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(q, e);
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge hclk);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// The watchdog allows well over the clock-mode wait of a few ticks.
	initial begin
		repeat (60000) @(posedge hclk);
		n_fail++;
		tally_and_finish();
	end

	initial begin
		hresetn = 1'b0;
		hsel = 1'b1;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		debug_halt = 1'b0;
		pin_run = 1'b0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(gpt_pkg::OFS_CFG, 32'h0);
		rd(gpt_pkg::OFS_CTL, 32'h0);
		rd(gpt_pkg::OFS_ACNT, 32'hFFFFFFFF);
		rd(gpt_pkg::OFS_BILR, 32'h0000FFFF);
		rd(gpt_pkg::OFS_APR, 32'h0);
		rd(gpt_pkg::OFS_BPR, 32'h0);
		rd(gpt_pkg::OFS_RIS, 32'h0);
		chk({31'h0, hresp}, 32'h0);
		wr(gpt_pkg::OFS_AILR, 32'hABCD0006);
		rd(gpt_pkg::OFS_BILR, 32'h0000ABCD);
		// Enable while halted: the joined load is taken and then held.
		debug_halt <= 1'b1;
		wr(gpt_pkg::OFS_CTL, 32'h3);
		rd(gpt_pkg::OFS_ACNT, 32'hABCD0006);
		rd(gpt_pkg::OFS_BCNT, 32'h0000ABCD);
		wr(gpt_pkg::OFS_CTL, 32'h0);
		debug_halt <= 1'b0;
		wr(gpt_pkg::OFS_AILR, 32'h00000006);
		wr(gpt_pkg::OFS_AMR, 32'h2);
		wr(gpt_pkg::OFS_BMR, 32'h1);
		wr(gpt_pkg::OFS_IMR, 32'h1);
		wr(gpt_pkg::OFS_CTL, 32'h21);
		idle(30);
		chk(32'(trig_gap), 32'h7);
		chk({31'h0, irq}, 32'h1);
		rd(gpt_pkg::OFS_RIS, 32'h1);
		rd(gpt_pkg::OFS_MIS, 32'h1);
		wr(gpt_pkg::OFS_AILR, 32'h00001000);
		wr(gpt_pkg::OFS_CTL, 32'h23);
		debug_halt <= 1'b1;
		xfer(1'b0, gpt_pkg::OFS_ACNT, 32'h0);
		q2 = q;
		idle(5);
		rd(gpt_pkg::OFS_ACNT, q2);
		debug_halt <= 1'b0;
		idle(5);
		xfer(1'b0, gpt_pkg::OFS_ACNT, 32'h0);
		chk({31'h0, q < q2}, 32'h1);
		wr(gpt_pkg::OFS_CTL, 32'h21);
		wr(gpt_pkg::OFS_AILR, 32'h00000003);
		idle(12);
		chk(32'(trig_gap), 32'h4);
		// Period three against clears every two cycles: one clear meets a reload.
		wr(gpt_pkg::OFS_AILR, 32'h00000002);
		wr(gpt_pkg::OFS_ICR, 32'h1);
		wr(gpt_pkg::OFS_ICR, 32'h1);
		wr(gpt_pkg::OFS_ICR, 32'h1);
		rd(gpt_pkg::OFS_RIS, 32'h1);
		wr(gpt_pkg::OFS_CTL, 32'h0);
		wr(gpt_pkg::OFS_ICR, 32'h1);
		rd(gpt_pkg::OFS_RIS, 32'h0);
		chk({31'h0, irq}, 32'h0);
		wr(gpt_pkg::OFS_AMR, 32'h1);
		wr(gpt_pkg::OFS_AILR, 32'h00000004);
		n0 = n_trig;
		wr(gpt_pkg::OFS_CTL, 32'h1);
		idle(20);
		rd(gpt_pkg::OFS_CTL, 32'h0);
		rd(gpt_pkg::OFS_RIS, 32'h1);
		rd(gpt_pkg::OFS_ACNT, 32'h00000004);
		chk(32'(n_trig - n0), 32'h0);
		wr(8'h80, 32'hFFFFFFFF);
		rd(8'h80, 32'h0);
		wr(gpt_pkg::OFS_ICR, 32'h1);
		wr(gpt_pkg::OFS_CFG, 32'h1);
		rd(gpt_pkg::OFS_ACNT, 32'h00000001);
		wr(gpt_pkg::OFS_AMAT, 32'h00000002);
		wr(gpt_pkg::OFS_IMR, 32'h8);
		debug_halt <= 1'b1;
		pin_run <= 1'b1;
		wr(gpt_pkg::OFS_CTL, 32'h13);
		for (int i = 0; i < 30000 && irq !== 1'b1; i++) @(posedge hclk);
		chk({31'h0, irq}, 32'h1);
		rd(gpt_pkg::OFS_ACNT, 32'h00000000);
		rd(gpt_pkg::OFS_RIS, 32'h8);
		rd(gpt_pkg::OFS_MIS, 32'h8);
		wr(gpt_pkg::OFS_ICR, 32'h8);
		rd(gpt_pkg::OFS_MIS, 32'h0);
		rd(gpt_pkg::OFS_RIS, 32'h0);
		pin_run <= 1'b0;
		debug_halt <= 1'b0;
		wr(gpt_pkg::OFS_CTL, 32'h0);
		wr(gpt_pkg::OFS_CFG, 32'h4);
		wr(gpt_pkg::OFS_AILR, 32'h00050003);
		rd(gpt_pkg::OFS_BILR, 32'h0);
		rd(gpt_pkg::OFS_AILR, 32'h00000003);
		tally_and_finish();
	end
endmodule
